// File: shared/port_a_pkg.sv
package port_a_pkg;

  // ****************************************************************
  // Register map, indices on the plain register port
  // ****************************************************************
  localparam logic [2:0] PIN_LEVEL_ADDR = 3'h0;
  localparam logic [2:0] OUTPUT_LATCH_ADDR = 3'h1;
  localparam logic [2:0] DIRECTION_ADDR = 3'h2;
  localparam logic [2:0] ANALOG_SELECT_ADDR = 3'h3;
  localparam logic [2:0] ALT_CONFIG_ADDR = 3'h4;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam logic [7:0] PORT_MASK = 8'hef;
  localparam logic [7:0] ANALOG_MASK_28 = 8'h1f;
  localparam logic [7:0] ANALOG_MASK_44 = 8'hff;
  localparam logic [7:0] ALT_CONFIG_MASK = 8'h07;
  localparam int UNUSED_BIT = 4;
  localparam int REF_VOLTAGE_OUT_EN_BIT = 0;
  localparam int OSC_MODE_LSB = 1;
  localparam int ANALOG_BIT_PIN5 = 4;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'hef;
  localparam logic [7:0] ANALOG_SELECT_RESET = 8'h00;
  localparam logic [7:0] ALT_CONFIG_RESET = 8'h06;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Set when the port is built for the larger package
  localparam logic PACKAGE_44_PIN = 1'b1;

  // Inactive level of the slave-select output when the pin is not an input
  localparam logic SLAVE_SELECT_IDLE = 1'b1;

  // ****************************************************************
  // Oscillator modes and clock-out divider
  // ****************************************************************
  typedef enum logic [1:0] {
    OSC_HS = 2'b00,
    OSC_RC = 2'b01,
    OSC_EC = 2'b10,
    OSC_INT = 2'b11
  } osc_mode_t;

  localparam int CYCLE_CLOCK_DIVIDE = 4;
  localparam int DIV_WIDTH = $clog2(CYCLE_CLOCK_DIVIDE);

endpackage : port_a_pkg

// File: hw/port_a_pin_mux_io.sv
`timescale 1ns/1ps

module port_a_pin_mux_io (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  // Pads
  input wire logic [7:0] pad_in_i,
  output logic [7:0] pad_out_o,
  output logic [7:0] pad_oe_n_o,
  // Peripheral outputs routed to pins 0, 1 and 5
  input wire logic [2:0] remap_drive_en_i,
  input wire logic [2:0] remap_drive_data_i,
  input wire logic parallel_addr_en_i,
  input wire logic parallel_addr_six_i,
  input wire logic parallel_addr_seven_i,
  // Pin inputs delivered to peripherals
  output logic [2:0] remap_in_o,
  output logic serial_slave_select_o,
  output logic transceiver_receive_in_o
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] output_latch_reg;
  logic [7:0] direction_reg;
  logic [7:0] analog_select_reg;
  logic [7:0] alt_config_reg;
  logic [7:0] next_output_latch_reg;
  logic [7:0] next_direction_reg;
  logic [7:0] next_analog_select_reg;
  logic [7:0] next_alt_config_reg;
  logic [7:0] pad_sync1;
  logic [7:0] pad_sync2;
  logic [port_a_pkg::DIV_WIDTH-1:0] div_count;
  logic [port_a_pkg::DIV_WIDTH-1:0] next_div_count;
  logic [7:0] next_reg_rdata;
  logic [7:0] next_pad_out;
  logic [7:0] next_pad_oe_n;
  logic [2:0] next_remap_in;
  logic next_serial_slave_select;
  logic next_transceiver_receive_in;

  // Derived controls
  logic [7:0] digital_enable_bits;
  logic [7:0] pin_level_reg;
  logic [7:0] analog_mask;
  logic ref_voltage_out_on;
  port_a_pkg::osc_mode_t osc_mode;
  logic clock_out_mode;
  logic osc_owns_pins;

  assign analog_mask = port_a_pkg::PACKAGE_44_PIN ? port_a_pkg::ANALOG_MASK_44 :
                       port_a_pkg::ANALOG_MASK_28;
  assign ref_voltage_out_on = alt_config_reg[port_a_pkg::REF_VOLTAGE_OUT_EN_BIT];
  assign osc_mode = port_a_pkg::osc_mode_t'(alt_config_reg[port_a_pkg::OSC_MODE_LSB +: 2]);
  assign clock_out_mode = (osc_mode == port_a_pkg::OSC_RC) || (osc_mode == port_a_pkg::OSC_EC);
  assign osc_owns_pins = (osc_mode != port_a_pkg::OSC_INT);

  // ****************************************************************
  // Input gating per pin
  // ****************************************************************
  // A cleared digital enable bit blocks the digital input to port reads, which then give zero; peripheral inputs are not gated
  always_comb begin
    digital_enable_bits = 8'h00;
    digital_enable_bits[0] = analog_select_reg[0];
    digital_enable_bits[1] = analog_select_reg[1];
    digital_enable_bits[2] = analog_select_reg[2] && !ref_voltage_out_on;
    digital_enable_bits[3] = analog_select_reg[3];
    digital_enable_bits[5] = analog_select_reg[port_a_pkg::ANALOG_BIT_PIN5];
    digital_enable_bits[6] = !osc_owns_pins;
    digital_enable_bits[7] = !osc_owns_pins;
    pin_level_reg = pad_sync2 & digital_enable_bits & direction_reg & port_a_pkg::PORT_MASK;
    // Output pins read back their own level, which the buffer still sees
    pin_level_reg = pin_level_reg |
                    (pad_sync2 & ~direction_reg & digital_enable_bits & port_a_pkg::PORT_MASK);
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_comb begin
    next_output_latch_reg = output_latch_reg;
    next_direction_reg = direction_reg;
    next_analog_select_reg = analog_select_reg;
    next_alt_config_reg = alt_config_reg;
    if (reg_write_i) begin
      case (reg_addr_i)
        port_a_pkg::PIN_LEVEL_ADDR,
        port_a_pkg::OUTPUT_LATCH_ADDR: begin
          next_output_latch_reg = reg_wdata_i & port_a_pkg::PORT_MASK;
        end
        port_a_pkg::DIRECTION_ADDR: begin
          next_direction_reg = reg_wdata_i & port_a_pkg::PORT_MASK;
        end
        port_a_pkg::ANALOG_SELECT_ADDR: begin
          next_analog_select_reg = reg_wdata_i & analog_mask;
        end
        port_a_pkg::ALT_CONFIG_ADDR: begin
          next_alt_config_reg = reg_wdata_i & port_a_pkg::ALT_CONFIG_MASK;
        end
        default: begin
          next_output_latch_reg = output_latch_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_latch_reg <= port_a_pkg::LATCH_RESET;
      direction_reg <= port_a_pkg::DIRECTION_RESET;
      analog_select_reg <= port_a_pkg::ANALOG_SELECT_RESET;
      alt_config_reg <= port_a_pkg::ALT_CONFIG_RESET;
    end else begin
      output_latch_reg <= next_output_latch_reg;
      direction_reg <= next_direction_reg;
      analog_select_reg <= next_analog_select_reg;
      alt_config_reg <= next_alt_config_reg;
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Data only stand in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    next_reg_rdata = port_a_pkg::READ_IDLE;
    if (reg_read_i) begin
      case (reg_addr_i)
        port_a_pkg::PIN_LEVEL_ADDR: next_reg_rdata = pin_level_reg;
        port_a_pkg::OUTPUT_LATCH_ADDR: next_reg_rdata = output_latch_reg;
        port_a_pkg::DIRECTION_ADDR: next_reg_rdata = direction_reg;
        port_a_pkg::ANALOG_SELECT_ADDR: next_reg_rdata = analog_select_reg;
        port_a_pkg::ALT_CONFIG_ADDR: next_reg_rdata = alt_config_reg;
        default: next_reg_rdata = port_a_pkg::READ_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pad drivers and cycle clock divider
  // ****************************************************************
  // Analog selection never appears here, so the driver ignores it
  always_comb begin
    next_div_count = div_count + 1'b1;
    next_pad_out = output_latch_reg;
    next_pad_oe_n = direction_reg | ~port_a_pkg::PORT_MASK;
    if (parallel_addr_en_i && port_a_pkg::PACKAGE_44_PIN) begin
      next_pad_out[0] = parallel_addr_six_i;
      next_pad_out[1] = parallel_addr_seven_i;
    end else begin
      if (remap_drive_en_i[0]) next_pad_out[0] = remap_drive_data_i[0];
      if (remap_drive_en_i[1]) next_pad_out[1] = remap_drive_data_i[1];
    end
    if (remap_drive_en_i[2]) next_pad_out[5] = remap_drive_data_i[2];
    if (ref_voltage_out_on) begin
      next_pad_oe_n[2] = 1'b1;
    end
    if (clock_out_mode) begin
      next_pad_out[6] = next_div_count[port_a_pkg::DIV_WIDTH-1];
      next_pad_oe_n[6] = 1'b0;
    end else if (osc_owns_pins) begin
      next_pad_oe_n[6] = 1'b1;
    end
    if (osc_owns_pins) begin
      next_pad_oe_n[7] = 1'b1;
    end
  end

  // ****************************************************************
  // Pin inputs to peripherals
  // ****************************************************************
  always_comb begin
    next_remap_in[0] = direction_reg[0] && pad_sync2[0];
    next_remap_in[1] = direction_reg[1] && pad_sync2[1];
    next_remap_in[2] = direction_reg[5] && pad_sync2[5];
    next_serial_slave_select = direction_reg[5] ? pad_sync2[5] :
                               port_a_pkg::SLAVE_SELECT_IDLE;
    next_transceiver_receive_in = direction_reg[5] && pad_sync2[5];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_sync1 <= 8'h00;
      pad_sync2 <= 8'h00;
      div_count <= '0;
      reg_rdata_o <= port_a_pkg::READ_IDLE;
      pad_out_o <= port_a_pkg::LATCH_RESET;
      pad_oe_n_o <= 8'hff;
      remap_in_o <= 3'h0;
      serial_slave_select_o <= port_a_pkg::SLAVE_SELECT_IDLE;
      transceiver_receive_in_o <= 1'b0;
    end else begin
      pad_sync1 <= pad_in_i;
      pad_sync2 <= pad_sync1;
      div_count <= next_div_count;
      reg_rdata_o <= next_reg_rdata;
      pad_out_o <= next_pad_out;
      pad_oe_n_o <= next_pad_oe_n;
      remap_in_o <= next_remap_in;
      serial_slave_select_o <= next_serial_slave_select;
      transceiver_receive_in_o <= next_transceiver_receive_in;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  analog_blocks_input_a: assert property (
    reg_read_i && reg_addr_i == port_a_pkg::PIN_LEVEL_ADDR && !analog_select_reg[0]
    |=> reg_rdata_o[0] == 1'b0)
    else $error("analog pin 0 leaked into port read");

  input_reaches_port_a: assert property (
    reg_read_i && reg_addr_i == port_a_pkg::PIN_LEVEL_ADDR && analog_select_reg[3]
    |=> reg_rdata_o[3] == $past(pad_sync2[3]))
    else $error("digital pin 3 level missing from port read");

  output_drives_latch_a: assert property (
    direction_reg[3] == 1'b0 |=> !pad_oe_n_o[3] && pad_out_o[3] == $past(output_latch_reg[3]))
    else $error("pin 3 not driven from latch");

  input_is_hiz_a: assert property (
    direction_reg[5] |=> pad_oe_n_o[5])
    else $error("pin 5 driven while direction is input");

  // Read data are judged from the cycle that held the reference output on
  ref_blocks_pin_a: assert property (
    ref_voltage_out_on |=> pad_oe_n_o[2] && (!$past(reg_read_i)
    || $past(reg_addr_i) != port_a_pkg::PIN_LEVEL_ADDR || reg_rdata_o[2] == 1'b0))
    else $error("pin 2 digital path active with reference output");

  clock_out_period_a: assert property (
    clock_out_mode [*3] |=> pad_out_o[6] != $past(pad_out_o[6], 2) && !pad_oe_n_o[6])
    else $error("cycle clock on pin 6 not at one quarter rate");

  latch_write_a: assert property (
    reg_write_i && reg_addr_i == port_a_pkg::PIN_LEVEL_ADDR
    |=> output_latch_reg == ($past(reg_wdata_i) & port_a_pkg::PORT_MASK))
    else $error("port write did not reach latch");

  unused_bit_zero_a: assert property (
    reg_read_i && reg_addr_i != port_a_pkg::ANALOG_SELECT_ADDR |=> reg_rdata_o[4] == 1'b0)
    else $error("bit 4 read back non-zero");

  slave_select_path_a: assert property (
    direction_reg[5] |=> serial_slave_select_o == $past(pad_sync2[5]))
    else $error("slave select does not follow pin 5");

  receive_path_a: assert property (
    !direction_reg[5] |=> !transceiver_receive_in_o)
    else $error("receive input active while pin 5 is output");

  remap_input_a: assert property (
    direction_reg[0] |=> remap_in_o[0] == $past(pad_sync2[0]))
    else $error("remap input 0 does not follow pin 0");

  osc_pin7_a: assert property (
    osc_owns_pins |=> pad_oe_n_o[7])
    else $error("pin 7 driven while oscillator owns it");

  hs_pin6_off_a: assert property (
    osc_owns_pins && !clock_out_mode |=> pad_oe_n_o[6])
    else $error("pin 6 driven while oscillator feedback owns it");

  parallel_addr_drive_a: assert property (
    parallel_addr_en_i
    |=> pad_out_o[1:0] == $past({parallel_addr_seven_i, parallel_addr_six_i}))
    else $error("parallel address not on pins 0 and 1");

  latch_readback_a: assert property (
    reg_read_i && reg_addr_i == port_a_pkg::OUTPUT_LATCH_ADDR
    |=> reg_rdata_o == $past(output_latch_reg))
    else $error("latch read back wrong value");

  rdata_idle_a: assert property (
    !reg_read_i |=> reg_rdata_o == port_a_pkg::READ_IDLE)
    else $error("read data not idle outside a read");

endmodule : port_a_pin_mux_io

// File: verif/pin_far_side.sv
`timescale 1ns/1ps

// Far-side circuitry on the pads; device drive always wins, no contention modelled
module pin_far_side (
  // Clock
  input wire logic clk_i,
  // Device pads
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_n_i,
  // Bench control of the external drivers
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pad_o
);
  logic [7:0] flt = 8'h5a;

  // A line nobody drives has no pull, so it wanders every cycle
  always_ff @(posedge clk_i) begin
    flt <= ~flt;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_o[i] = !pad_oe_n_i[i] ? pad_out_i[i] : (ext_en_i[i] ? ext_val_i[i] : flt[i]);
    end
  end
endmodule : pin_far_side

// File: verif/port_a_pin_mux_io_tb_top.sv
`timescale 1ns/1ps

module port_a_pin_mux_io_tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [7:0] reg_rdata_o, pad_in_i, pad_out_o, pad_oe_n_o;
  logic [2:0] ren = 3'h0, rdat = 3'h0, remap_in_o;
  logic pen = 1'b0, p6 = 1'b0, p7 = 1'b0, serial_slave_select_o, transceiver_receive_in_o;
  logic [7:0] ext = 8'h00, lat, dir, ana, alt, drv, lvl, dm;
  logic [15:0] seed = 16'h003a;
  logic [5:0] q;
  int err_total = 0, cmp_count = 0, cyc = 0;

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  port_a_pin_mux_io u_port_a_pin_mux_io (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .remap_drive_en_i(ren),
    .remap_drive_data_i(rdat), .parallel_addr_en_i(pen), .parallel_addr_six_i(p6),
    .parallel_addr_seven_i(p7), .remap_in_o(remap_in_o),
    .serial_slave_select_o(serial_slave_select_o),
    .transceiver_receive_in_o(transceiver_receive_in_o));

  pin_far_side u_pin_far_side (.clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
    .ext_en_i(8'hff), .ext_val_i(ext), .pad_o(pad_in_i));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Pin 0/1 priority: parallel address over remap over latch
  function automatic logic [7:0] out_exp();
    logic [7:0] o;
    o = lat;
    if (ren[0]) o[0] = rdat[0];
    if (ren[1]) o[1] = rdat[1];
    if (ren[2]) o[5] = rdat[2];
    if (pen) o[1:0] = {p7, p6};
    return o;
  endfunction : out_exp

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask : wr

  task rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask : rdc

  task end_of_test();
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // Hang guard, far above the thousand or so cycles the tests need
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    ext <= 8'hb7;
    #1;
    chk(pad_oe_n_o, 8'hff);
    repeat (4) @(posedge clk_i);
    rdc(3'h1, 8'h00);
    rdc(3'h2, 8'hef);
    rdc(3'h3, 8'h00);
    rdc(3'h0, 8'h80);
    wr(3'h5, 8'hff);
    for (int a = 5; a < 8; a++) rdc(3'(a), 8'h00);
    rdc(3'h1, 8'h00);
    $display("reset and unmapped test done");
    for (int n = 0; n < 40; n++) begin
      seed = lfsr(lfsr(lfsr(seed)));
      {lat, dir, ana} = n == 0 ? 24'hff00ff : {seed, seed[7:0] ^ seed[15:8]};
      alt = n == 0 ? 8'h07 : 8'h06 | {7'h0, seed[3]};
      wr(port_a_pkg::ANALOG_SELECT_ADDR, ana);
      wr(seed[8] ? port_a_pkg::PIN_LEVEL_ADDR : port_a_pkg::OUTPUT_LATCH_ADDR, lat);
      wr(port_a_pkg::DIRECTION_ADDR, dir);
      wr(port_a_pkg::ALT_CONFIG_ADDR, alt);
      ren <= seed[2:0];
      rdat <= seed[6:4];
      {pen, p6, p7} <= seed[11:9];
      ext <= seed[15:8] ^ 8'h3c;
      repeat (6) @(posedge clk_i);
      #1;
      drv = ~dir & 8'hef & ~{5'h0, alt[0], 2'h0};
      lvl = (drv & out_exp()) | (~drv & ext);
      dm = {2'b11, ana[4], 1'b0, ana[3:0]} & ~{5'h0, alt[0], 2'h0};
      chk(pad_oe_n_o, ~drv);
      chk(pad_out_o & drv, out_exp() & drv);
      chk({5'h0, remap_in_o}, {5'h0, {lvl[5], lvl[1:0]} & {dir[5], dir[1:0]}});
      chk({6'h0, serial_slave_select_o, transceiver_receive_in_o},
          {6'h0, dir[5] ? lvl[5] : 1'b1, dir[5] & lvl[5]});
      rdc(3'h0, lvl & dm);
      rdc(3'h1, lat & 8'hef);
      rdc(3'h2, dir & 8'hef);
      rdc(3'h3, ana);
    end
    $display("random pin test done");
    wr(port_a_pkg::DIRECTION_ADDR, 8'hff);
    for (int m = 0; m < 4; m++) begin
      wr(port_a_pkg::ALT_CONFIG_ADDR, 8'(m << 1));
      repeat (6) @(posedge clk_i);
      for (int k = 0; k < 6; k++) begin
        @(posedge clk_i);
        #1;
        q[k] = pad_out_o[6];
      end
      if (m == 1 || m == 2) begin
        chk({7'h0, pad_oe_n_o[6]}, 8'h00);
        for (int k = 0; k < 4; k++) chk({7'h0, q[k + 2]}, {7'h0, ~q[k]});
      end
      chk({6'h0, pad_oe_n_o[7:6]}, {6'h0, 1'b1, !(m == 1 || m == 2)});
      rdc(3'h0, ext & {{2{m == 3}}, ana[4], 1'b0, ana[3:0]});
    end
    $display("oscillator mode test done");
    end_of_test();
  end
endmodule : port_a_pin_mux_io_tb_top
